// >>> crm_mode_regs.sv
// Mode selection, serial register bank and USB identity hand-off of the card reader bridge.
module crm_mode_regs
  import crm_pkg::*;
#(
  parameter logic [6:0]  DEV_ADDR    = 7'h2A,    // Arbitrary bus address.
  parameter logic [15:0] DEFAULT_VID = 16'h1234, // Arbitrary value.
  parameter logic [15:0] DEFAULT_PID = 16'h5678  // Arbitrary value.
)(
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       usb_clk,
  input  wire logic       usb_srst,
  input  wire logic       iface_select,
  input  wire logic       mode_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic [6:0] irq_events_first,
  input  wire logic       irq_event_fw,
  input  wire logic       bridge_err,
  output logic            int_pin,
  output logic            passthru,
  output logic            mcu_on,
  output logic            usb_to_reader,
  output logic            reader_port_one,
  output logic            reader_port_two,
  output logic            port_one_switch_close,
  output logic            port_two_switch_close,
  output crm_cfg_type     active_cfg,
  output crm_usb_id_type  usb_id
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0]     regs_reg [CRM_NUM_REGS];
  logic [7:0]     irq1_reg, irq2_reg;
  logic           sel_meta_reg, sel_sync_reg, strap_done_reg, i2c_mode_reg;
  logic           mode_meta_reg, mode_sync_reg;
  logic           scl_meta_reg, scl_sync_reg, scl_prev_reg;
  logic           sda_meta_reg, sda_sync_reg, sda_prev_reg;
  crm_state_type  state_reg, after_ack_reg;
  logic [7:0]     shift_reg, ptr_reg;
  logic [3:0]     cnt_reg;
  logic           wr_en, rd_en;
  logic [7:0]     rd_data;
  logic           card1_req, card2_req, awake_req, cfg_load;
  crm_sel_type    sel;
  crm_cfg_type    cfg_now;
  crm_usb_id_type id_now, sent_reg, usb_id_reg;
  logic           req_tgl_reg, ack_meta_reg, ack_sync_reg;
  logic           ureq_meta_reg, ureq_sync_reg, ureq_prev_reg, uack_reg;
  logic           scl_rise, scl_fall, bus_start, bus_stop;
  logic [7:0]     irq1_set, irq2_set;
  logic           irq_pend, irq_new, irq_assert;

  // Writable bits of each register; everything else stays zero.
  function automatic logic [7:0] reg_mask(input logic [7:0] ofs);
    case (ofs)
      CRM_OFS_CONTROL: reg_mask = CRM_MASK_CTL;
      CRM_OFS_CFG1:    reg_mask = CRM_MASK_CFG1;
      CRM_OFS_CFG2:    reg_mask = CRM_MASK_CFG2;
      CRM_OFS_IE1:     reg_mask = CRM_MASK_IE1;
      CRM_OFS_IE2:     reg_mask = CRM_MASK_IE2;
      default:         reg_mask = CRM_MASK_FULL;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers and strap capture
  // ----------------------------------------------------------------
  // Two flops per pin, and a third on the bus pins for edges; the first flop never feeds logic.
  always_ff @(posedge clk)
  begin
    sel_meta_reg  <= iface_select;
    sel_sync_reg  <= sel_meta_reg;
    mode_meta_reg <= mode_in;
    mode_sync_reg <= mode_meta_reg;
    scl_meta_reg  <= scl_in;
    scl_sync_reg  <= scl_meta_reg;
    scl_prev_reg  <= scl_sync_reg;
    sda_meta_reg  <= sda_in;
    sda_sync_reg  <= sda_meta_reg;
    sda_prev_reg  <= sda_sync_reg;
  end

  // strap caught once
  // The select pin must not move later, so it is sampled once after reset.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      strap_done_reg <= 1'b0;
      i2c_mode_reg   <= 1'b0;
    end
    else if (!strap_done_reg)
    begin
      strap_done_reg <= 1'b1;
      i2c_mode_reg   <= sel_sync_reg;
    end
  end

  // ----------------------------------------------------------------
  // Serial register port
  // ----------------------------------------------------------------
  assign scl_rise  = scl_sync_reg && !scl_prev_reg;
  assign scl_fall  = !scl_sync_reg && scl_prev_reg;
  assign bus_start = scl_sync_reg && scl_prev_reg && sda_prev_reg && !sda_sync_reg;
  assign bus_stop  = scl_sync_reg && scl_prev_reg && !sda_prev_reg && sda_sync_reg;
  assign wr_en     = scl_fall && state_reg == CRM_ST_WDAT && cnt_reg == CRM_BYTE_BITS;
  assign rd_en     = scl_fall && (after_ack_reg == CRM_ST_RDAT)
                     && (state_reg == CRM_ST_ACK || state_reg == CRM_ST_MACK);

  // serve host accesses
  // Pointer byte after the address, then bytes auto-increment the pointer.
  always_ff @(posedge clk)
  begin
    if (srst || !i2c_mode_reg || bus_stop)
    begin
      state_reg     <= CRM_ST_IDLE;
      after_ack_reg <= CRM_ST_IDLE;
      shift_reg     <= 8'h00;
      cnt_reg       <= 4'h0;
      ptr_reg       <= 8'h00;
      sda_oe        <= 1'b0;
    end
    else if (bus_start)
    begin
      state_reg <= CRM_ST_ADDR;
      cnt_reg   <= 4'h0;
      sda_oe    <= 1'b0;
    end
    else
    begin
      case (state_reg)
        CRM_ST_ADDR, CRM_ST_PTR, CRM_ST_WDAT:
        begin
          if (scl_rise)
          begin
            shift_reg <= {shift_reg[6:0], sda_sync_reg};
            cnt_reg   <= cnt_reg + 4'h1;
          end
          else if (scl_fall && cnt_reg == CRM_BYTE_BITS)
          begin
            cnt_reg   <= 4'h0;
            sda_oe    <= 1'b1;
            state_reg <= CRM_ST_ACK;
            if (state_reg == CRM_ST_ADDR)
            begin
              after_ack_reg <= shift_reg[0] ? CRM_ST_RDAT : CRM_ST_PTR;
              if (shift_reg[7:1] != DEV_ADDR)
              begin
                sda_oe    <= 1'b0;
                state_reg <= CRM_ST_IDLE;
              end
            end
            else if (state_reg == CRM_ST_PTR)
            begin
              ptr_reg       <= shift_reg;
              after_ack_reg <= CRM_ST_WDAT;
            end
            else
            begin
              ptr_reg       <= ptr_reg + 8'h01;
              after_ack_reg <= CRM_ST_WDAT;
            end
          end
        end
        CRM_ST_ACK, CRM_ST_MACK:
        begin
          if (state_reg == CRM_ST_MACK && scl_rise && sda_sync_reg)
            state_reg <= CRM_ST_IDLE; // Master refused: read ends.
          else if (scl_fall)
          begin
            state_reg <= after_ack_reg;
            cnt_reg   <= 4'h0;
            sda_oe    <= 1'b0;
            if (after_ack_reg == CRM_ST_RDAT)
            begin
              shift_reg <= rd_data;
              sda_oe    <= !rd_data[7];
              ptr_reg   <= ptr_reg + 8'h01;
            end
          end
        end
        CRM_ST_RDAT:
        begin
          if (scl_rise)
            cnt_reg <= cnt_reg + 4'h1;
          else if (scl_fall && cnt_reg == CRM_BYTE_BITS)
          begin
            sda_oe    <= 1'b0;
            state_reg <= CRM_ST_MACK;
          end
          else if (scl_fall)
          begin
            shift_reg <= {shift_reg[6:0], 1'b0};
            sda_oe    <= !shift_reg[6];
          end
        end
        default:
          state_reg <= CRM_ST_IDLE;
      endcase
    end
  end

  // Open-drain data line only ever pulls low.
  always_ff @(posedge clk)
  begin
    sda_out <= 1'b0;
  end

  always_comb
  begin
    rd_data = 8'h00;
    if (ptr_reg < 8'(CRM_NUM_REGS))
      rd_data = regs_reg[ptr_reg[3:0]];
    else if (ptr_reg == CRM_OFS_IRQ1)
      rd_data = irq1_reg;
    else if (ptr_reg == CRM_OFS_IRQ2)
      rd_data = irq2_reg;
  end

  // ----------------------------------------------------------------
  // Register bank
  // ----------------------------------------------------------------
  // reset values
  // Identity bytes reset to zero so the built-in codes are used.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      for (int i = 0; i < CRM_NUM_REGS; i++)
        regs_reg[i] <= (i == 0) ? CRM_RST_CONTROL : CRM_RST_ZERO;
    end
    else if (wr_en && ptr_reg < 8'(CRM_NUM_REGS))
      regs_reg[ptr_reg[3:0]] <= shift_reg & reg_mask(ptr_reg);
  end

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  // field positions
  assign sel = crm_sel_type'(regs_reg[0][CRM_CTL_SEL +: 2]);
  assign card1_req = i2c_mode_reg ? (regs_reg[0][CRM_CTL_WAKE] && sel == CRM_SEL_CARD1) : mode_sync_reg;
  assign card2_req = i2c_mode_reg && regs_reg[0][CRM_CTL_WAKE] && sel == CRM_SEL_CARD2;
  assign awake_req = strap_done_reg && (card1_req || card2_req);

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      passthru        <= 1'b1;
      mcu_on          <= 1'b0;
      usb_to_reader   <= 1'b0;
      reader_port_one <= 1'b0;
      reader_port_two <= 1'b0;
    end
    else
    begin
      passthru        <= !awake_req;
      mcu_on          <= awake_req;
      usb_to_reader   <= awake_req;
      reader_port_one <= awake_req && card1_req;
      reader_port_two <= awake_req && card2_req;
    end
  end

  // independent switch sets
  // A port taken by the reader ignores its switch bit.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      port_one_switch_close <= 1'b1;
      port_two_switch_close <= 1'b1;
    end
    else
    begin
      port_one_switch_close <= (regs_reg[0][CRM_CTL_SW1] || !i2c_mode_reg) && !(awake_req && card1_req);
      port_two_switch_close <= regs_reg[0][CRM_CTL_SW2] && i2c_mode_reg && !(awake_req && card2_req);
    end
  end

  // ----------------------------------------------------------------
  // Deferred reader settings
  // ----------------------------------------------------------------
  // field decode
  // Simple control forces the reset settings.
  assign cfg_now = i2c_mode_reg ? crm_cfg_type'{
                     narrow_bus:       {regs_reg[1][CRM_CFG1_NB2], regs_reg[1][CRM_CFG1_NB1]},
                     ref_clock_select: regs_reg[2][4:0],
                     force_full_speed: regs_reg[2][CRM_CFG2_FS],
                     clock_limit:      regs_reg[3]} : crm_cfg_type'(0);
  assign cfg_load = awake_req && (!mcu_on || (card1_req != reader_port_one));

  always_ff @(posedge clk)
  begin
    if (srst)
      active_cfg <= crm_cfg_type'(0);
    else if (cfg_load)
      active_cfg <= cfg_now;
  end

  // ----------------------------------------------------------------
  // Interrupt output
  // ----------------------------------------------------------------
  assign irq1_set   = {1'b0, irq_events_first} & regs_reg[4] & {8{i2c_mode_reg}};
  assign irq2_set   = {7'h00, irq_event_fw} & regs_reg[5] & {8{i2c_mode_reg}};
  assign irq_pend   = |{irq1_reg, irq2_reg};
  assign irq_new    = |{irq1_set, irq2_set};
  assign irq_assert = regs_reg[1][CRM_CFG1_PULSE] ? irq_new : irq_pend;

  // held until status read
  // A new event beats the read that would clear it.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      irq1_reg <= 8'h00;
      irq2_reg <= 8'h00;
    end
    else
    begin
      irq1_reg <= ((rd_en && ptr_reg == CRM_OFS_IRQ1) ? 8'h00 : irq1_reg) | irq1_set;
      irq2_reg <= ((rd_en && ptr_reg == CRM_OFS_IRQ2) ? 8'h00 : irq2_reg) | irq2_set;
    end
  end

  // polarity select
  // Under simple control the pin is the active-low bridge error.
  always_ff @(posedge clk)
  begin
    if (srst)
      int_pin <= 1'b1;
    else if (!i2c_mode_reg)
      int_pin <= !bridge_err;
    else
      int_pin <= regs_reg[1][CRM_CFG1_POL] ? irq_assert : !irq_assert;
  end

  // ----------------------------------------------------------------
  // USB identity crossing
  // ----------------------------------------------------------------
  // built-in identity
  assign id_now = '{force_full_speed: active_cfg.force_full_speed,
                    vendor_id:  ({regs_reg[6], regs_reg[7]} == 16'h0000) ? DEFAULT_VID : {regs_reg[6], regs_reg[7]},
                    product_id: ({regs_reg[8], regs_reg[9]} == 16'h0000) ? DEFAULT_PID : {regs_reg[8], regs_reg[9]}};

  // Toggle handshake; the word holds still until the far side echoes.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      sent_reg     <= crm_usb_id_type'(0);
      req_tgl_reg  <= 1'b0;
      ack_meta_reg <= 1'b0;
      ack_sync_reg <= 1'b0;
    end
    else
    begin
      ack_meta_reg <= uack_reg;
      ack_sync_reg <= ack_meta_reg;
      if (req_tgl_reg == ack_sync_reg && id_now != sent_reg)
      begin
        sent_reg    <= id_now;
        req_tgl_reg <= !req_tgl_reg;
      end
    end
  end

  // Link-side capture of the identity word.
  always_ff @(posedge usb_clk)
  begin
    if (usb_srst)
    begin
      ureq_meta_reg <= 1'b0;
      ureq_sync_reg <= 1'b0;
      ureq_prev_reg <= 1'b0;
      uack_reg      <= 1'b0;
      usb_id_reg    <= crm_usb_id_type'(0);
    end
    else
    begin
      ureq_meta_reg <= req_tgl_reg;
      ureq_sync_reg <= ureq_meta_reg;
      ureq_prev_reg <= ureq_sync_reg;
      uack_reg      <= ureq_sync_reg;
      if (ureq_sync_reg != ureq_prev_reg)
        usb_id_reg <= sent_reg;
    end
  end
  assign usb_id = usb_id_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_CTRL_RESET: assert property (@(posedge clk) $past(srst) && !srst |-> regs_reg[0] == 8'h18)
    else $error("Control register not at reset value.");
  AST_SLEEP_PASS: assert property (@(posedge clk) disable iff (srst) !awake_req |=> passthru && !mcu_on)
    else $error("Sleep did not give pass-through.");
  AST_SW_WRITE: assert property (@(posedge clk) disable iff (srst)
    wr_en && ptr_reg == 8'h00 && !awake_req ##1 !awake_req |=> port_one_switch_close == $past(shift_reg[3], 2))
    else $error("Switch write not applied in pass-through.");
  AST_DEFER: assert property (@(posedge clk) disable iff (srst) !cfg_load |=> $stable(active_cfg))
    else $error("Reader settings changed outside entry.");
  AST_INT_LEVEL: assert property (@(posedge clk) disable iff (srst)
    i2c_mode_reg && !regs_reg[1][1] && irq_pend |=> int_pin == $past(regs_reg[1][0]))
    else $error("Held interrupt not asserted.");
  AST_ONE_CARD: assert property (@(posedge clk) disable iff (srst) !i2c_mode_reg |-> !reader_port_two)
    else $error("Second card used under simple control.");
  AST_READER: assert property (@(posedge clk) disable iff (srst) awake_req && card1_req |=> reader_port_one && usb_to_reader)
    else $error("Card 1 not routed to reader.");
  AST_VID: assert property (@(posedge clk) disable iff (srst)
    {regs_reg[6], regs_reg[7]} == 16'h0000 && req_tgl_reg == ack_sync_reg |=> sent_reg.vendor_id == DEFAULT_VID)
    else $error("Built-in vendor code not used.");
  AST_UNDEF: assert property (@(posedge clk) disable iff (srst) regs_reg[1][7:4] == 4'h0 && regs_reg[0][7:5] == 3'h0)
    else $error("Undefined bits became set.");
  AST_USB_XFER: assert property (@(posedge usb_clk) disable iff (usb_srst)
    ureq_sync_reg != ureq_prev_reg |=> usb_id_reg == $past(sent_reg))
    else $error("Identity word not captured.");
endmodule

// >>> crm_pkg.sv
// Package of constants and types for the card reader mode and configuration registers.
package crm_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CRM_OFS_CONTROL = 8'h00;
  localparam logic [7:0] CRM_OFS_CFG1    = 8'h01;
  localparam logic [7:0] CRM_OFS_CFG2    = 8'h02;
  localparam logic [7:0] CRM_OFS_CFG3    = 8'h03;
  localparam logic [7:0] CRM_OFS_IE1     = 8'h04;
  localparam logic [7:0] CRM_OFS_IE2     = 8'h05;
  localparam logic [7:0] CRM_OFS_VIDH    = 8'h06;
  localparam logic [7:0] CRM_OFS_VIDL    = 8'h07;
  localparam logic [7:0] CRM_OFS_PIDH    = 8'h08;
  localparam logic [7:0] CRM_OFS_PIDL    = 8'h09;
  localparam logic [7:0] CRM_OFS_IRQ1    = 8'h10;
  localparam logic [7:0] CRM_OFS_IRQ2    = 8'h11;
  localparam int         CRM_NUM_REGS    = 10;
  // ----------------------------------------------------------------
  // Reset values and writable bit masks
  // ----------------------------------------------------------------
  localparam logic [7:0] CRM_RST_CONTROL = 8'h18;
  localparam logic [7:0] CRM_RST_ZERO    = 8'h00;
  localparam logic [7:0] CRM_MASK_CTL    = 8'h1F;
  localparam logic [7:0] CRM_MASK_CFG1   = 8'h0F;
  localparam logic [7:0] CRM_MASK_CFG2   = 8'h3F;
  localparam logic [7:0] CRM_MASK_IE1    = 8'h7F;
  localparam logic [7:0] CRM_MASK_IE2    = 8'h01;
  localparam logic [7:0] CRM_MASK_FULL   = 8'hFF;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CRM_CTL_WAKE   = 0;
  localparam int CRM_CTL_SEL    = 1;
  localparam int CRM_CTL_SW1    = 3;
  localparam int CRM_CTL_SW2    = 4;
  localparam int CRM_CFG1_POL   = 0;
  localparam int CRM_CFG1_PULSE = 1;
  localparam int CRM_CFG1_NB1   = 2;
  localparam int CRM_CFG1_NB2   = 3;
  localparam int CRM_CFG2_FS    = 5;
  localparam logic [3:0] CRM_BYTE_BITS = 4'h8;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CRM_SEL_NONE  = 2'b00,
    CRM_SEL_CARD1 = 2'b01,
    CRM_SEL_CARD2 = 2'b10,
    CRM_SEL_RSVD  = 2'b11
  } crm_sel_type;
  typedef enum logic [2:0] {
    CRM_ST_IDLE = 3'b000,
    CRM_ST_ADDR = 3'b001,
    CRM_ST_PTR  = 3'b010,
    CRM_ST_WDAT = 3'b011,
    CRM_ST_ACK  = 3'b100,
    CRM_ST_RDAT = 3'b101,
    CRM_ST_MACK = 3'b110
  } crm_state_type;
  // Card reader settings that only take effect on reader entry or when the selected card changes.
  typedef struct packed {
    logic [1:0] narrow_bus;
    logic [4:0] ref_clock_select;
    logic       force_full_speed;
    logic [7:0] clock_limit;
  } crm_cfg_type;
  // Identity words handed to the USB side.
  typedef struct packed {
    logic        force_full_speed;
    logic [15:0] vendor_id;
    logic [15:0] product_id;
  } crm_usb_id_type;
endpackage

// >>> crm_host_model.sv
// Host side model: a serial bus master that reaches the register bank.
module crm_host_model
#(
  parameter logic [6:0] ADDR = 7'h2A // Arbitrary bus address.
)(
  input  wire logic clk,
  input  wire logic sda_in,
  output logic      scl,
  output logic      sda_low
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Bus phases
  // ----------------------------------------------------------------
  // Half periods sit well above the eight-cycle floor of the oversampler.
  localparam int HALF = 16;
  initial
  begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end
  // Data moves a few cycles after the clock falls, never in the same step.
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic bit_io(input logic b, output logic s);
    hold(4);
    sda_low <= !b;
    hold(HALF);
    scl <= 1'b1;
    hold(HALF);
    s = sda_in;
    scl <= 1'b0;
  endtask
  task automatic start();
    hold(4);
    sda_low <= 1'b0;
    hold(HALF);
    scl <= 1'b1;
    hold(HALF);
    sda_low <= 1'b1;
    hold(HALF);
    scl <= 1'b0;
  endtask
  task automatic stop();
    hold(4);
    sda_low <= 1'b1;
    hold(HALF);
    scl <= 1'b1;
    hold(HALF);
    sda_low <= 1'b0;
    hold(HALF);
  endtask
  // A byte, MSB first; the ninth bit is released and ack comes back high.
  task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(1'b1, ack);
    ack = !ack;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic       k0, k1, k2;
    start();
    xfer({ADDR, 1'b0}, q, k0);
    xfer(a, q, k1);
    xfer(d, q, k2);
    stop();
    ok = k0 && k1 && k2;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic       k0, k1, k2, k3;
    start();
    xfer({ADDR, 1'b0}, q, k0);
    xfer(a, q, k1);
    start();
    xfer({ADDR, 1'b1}, q, k2);
    xfer(8'hFF, d, k3);
    stop();
    ok = k0 && k1 && k2;
  endtask
endmodule

// >>> card_reader_mode_config_regs_test.sv
// Self-checking bench for the card reader mode and register bank.
module card_reader_mode_config_regs_test import crm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] VID = 16'h1357; // Arbitrary value.
  localparam logic [15:0] PID = 16'h2468; // Arbitrary value.
  logic           clk, usb_clk, srst, usb_srst, scl, sda_low, sda_oe, sda, int_pin, ok;
  logic           passthru, mcu_on, to_rdr, rdr1, rdr2, sw1, sw2, iface_sel, mode, berr, fw_ev;
  logic [6:0]     irq_ev;
  logic [7:0]     q;
  logic [7:0]     mask [0:9] = '{8'h1F, 8'h0F, 8'h3F, 8'hFF, 8'h7F, 8'h01, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  crm_cfg_type    cfg;
  crm_usb_id_type uid;
  int             num_errors = 0;
  int             checks_done = 0;
  // ----------------------------------------------------------------
  // Design, host model and open-drain data line
  // ----------------------------------------------------------------
  assign sda = !(sda_low || sda_oe);
  crm_mode_regs #(.DEFAULT_VID(VID), .DEFAULT_PID(PID)) i_dut (
    .clk(clk), .srst(srst), .usb_clk(usb_clk), .usb_srst(usb_srst), .iface_select(iface_sel),
    .mode_in(mode), .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
    .irq_events_first(irq_ev), .irq_event_fw(fw_ev), .bridge_err(berr), .int_pin(int_pin),
    .passthru(passthru), .mcu_on(mcu_on), .usb_to_reader(to_rdr), .reader_port_one(rdr1),
    .reader_port_two(rdr2), .port_one_switch_close(sw1), .port_two_switch_close(sw2),
    .active_cfg(cfg), .usb_id(uid));
  crm_host_model i_host (.clk(clk), .sda_in(sda), .scl(scl), .sda_low(sda_low));
  // ----------------------------------------------------------------
  // Clocks, watchdog and shared tasks
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #2 clk = !clk;
  end
  // The link clock starts off phase so its edges never line up with clk.
  initial
  begin
    usb_clk = 1'b0;
    #5;
    forever #32 usb_clk = !usb_clk;
  end
  initial
  begin
    repeat (100000) @(posedge clk);
    num_errors++;
    complete_run();
  end
  task automatic chk(input string name, input logic [32:0] got, input logic [32:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    i_host.wr(a, d, ok);
    chk("write ack", 33'(ok), 33'(1));
  endtask
  task automatic r(input logic [7:0] a);
    i_host.rd(a, q, ok);
    chk("read ack", 33'(ok), 33'(1));
  endtask
  task automatic complete_run();
    if (num_errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    srst = 1'b1;
    usb_srst = 1'b1;
    irq_ev = 7'h00;
    fw_ev = 1'b0;
    // strap held fixed
    // The strap only moves under reset, which here stands for a fresh power-up.
    iface_sel = 1'b1;
    mode = 1'b0;
    berr = 1'b0;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    usb_srst <= 1'b0;
    repeat (8) @(posedge clk);
    chk("sleep outputs", 33'({passthru, mcu_on, sw2, sw1}), 33'(4'b1011));
    for (int i = 0; i < 10; i++)
    begin
      r(8'(i));
      chk("reset value", 33'(q), 33'((i == 0) ? 8'h18 : 8'h00));
    end
    chk("default id", 33'(uid), 33'({1'b0, VID, PID}));
    // Every register is flooded with ones; undefined bits must not stick.
    for (int i = 0; i < 10; i++)
    begin
      w(8'(i), 8'hFF);
      r(8'(i));
      chk("masked value", 33'(q), 33'(mask[i]));
    end
    w(8'h0C, 8'h5A);
    chk("held cfg", 33'(cfg), 33'(0));
    chk("reserved select", 33'({mcu_on, passthru}), 33'(2'b01));
    w(8'h01, 8'h00);
    w(8'h00, 8'h13);
    repeat (8) @(posedge clk);
    chk("reader outputs", 33'({mcu_on, passthru, to_rdr, rdr1, rdr2, sw2}), 33'(6'b101101));
    chk("active cfg", 33'(cfg), 33'({2'b00, 5'h1F, 1'b1, 8'hFF}));
    repeat (200) @(posedge clk);
    chk("programmed id", 33'(uid), 33'({1'b1, 32'hFFFFFFFF}));
    irq_ev <= 7'h01;
    fw_ev <= 1'b1;
    @(posedge clk);
    irq_ev <= 7'h00;
    fw_ev <= 1'b0;
    repeat (100) @(posedge clk);
    chk("int held low", 33'(int_pin), 33'(0));
    r(8'h10);
    chk("latched flag", 33'(q[0]), 33'(1));
    chk("int still held", 33'(int_pin), 33'(0));
    r(8'h11);
    chk("firmware flag", 33'(q[0]), 33'(1));
    chk("int released", 33'(int_pin), 33'(1));
    // Pulse style, active high: one event gives a single high cycle.
    w(8'h01, 8'h03);
    chk("int idle low", 33'(int_pin), 33'(0));
    irq_ev <= 7'h01;
    @(posedge clk);
    irq_ev <= 7'h00;
    @(posedge clk);
    chk("int pulse", 33'(int_pin), 33'(1));
    @(posedge clk);
    chk("pulse end", 33'(int_pin), 33'(0));
    w(8'h00, 8'h10);
    repeat (8) @(posedge clk);
    chk("asleep outputs", 33'({mcu_on, passthru, to_rdr, sw1, sw2}), 33'(5'b01001));
    // Second power-up with the strap low: the mode pin alone picks card 1.
    srst <= 1'b1;
    iface_sel <= 1'b0;
    mode <= 1'b1;
    berr <= 1'b1;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    repeat (8) @(posedge clk);
    chk("simple reader", 33'({mcu_on, passthru, to_rdr, rdr1, rdr2, sw1, sw2, int_pin}), 33'(8'hB0));
    chk("simple cfg", 33'(cfg), 33'(0));
    i_host.wr(8'h00, 8'h13, ok);
    chk("ignored ack", 33'(ok), 33'(0));
    mode <= 1'b0;
    berr <= 1'b0;
    repeat (8) @(posedge clk);
    chk("simple pass", 33'({mcu_on, passthru, to_rdr, rdr1, rdr2, sw1, sw2, int_pin}), 33'(8'h45));
    complete_run();
  end
endmodule
